/* gpalr_defines.vh */
// register map, field layout and reset values of the gpio port block
`ifndef GPALR_DEFINES_VH
`define GPALR_DEFINES_VH
`define GPALR_ADDR_W 12
`define GPALR_NUM_FIELDS 9
`define GPALR_F_DOUT 4'h0
`define GPALR_F_DIR 4'h1
`define GPALR_F_ALT 4'h2
`define GPALR_F_ALT_SET_SELECT_ONE 4'h3
`define GPALR_F_ALT_SET_SELECT_TWO 4'h4
`define GPALR_F_OD 4'h5
`define GPALR_F_HDRV 4'h6
`define GPALR_F_PULL 4'h7
`define GPALR_F_SMR 4'h8
`define GPALR_F_IN 4'h9
`define GPALR_OFF_LED_EN 12'h100
`define GPALR_OFF_LED_HI 12'h104
`define GPALR_OFF_LED_LO 12'h108
`define GPALR_OFF_RST_CTL 12'h10C
`define GPALR_RST_DIR 8'hFF
`define GPALR_RST_ZERO 8'h00
`define GPALR_MASK_S_A 8'h3F
`define GPALR_MASK_M_A 8'hFF
`define GPALR_MASK_M_B 8'h0F
`define GPALR_MASK_M_C 8'h0F
`define GPALR_MASK_L_BC 8'hFF
`define GPALR_MASK_D 8'h01
`define GPALR_PKG_SMALL 2'h0
`define GPALR_PKG_MID 2'h1
`define GPALR_PKG_LARGE 2'h2
`define GPALR_RESP_OKAY 2'h0
`define GPALR_RESP_SLVERR 2'h2
`endif

/* gpalr_sync.v */
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module gpalr_sync #(
  parameter WIDTH = 32
) (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire [WIDTH-1:0] async_in, // raw pin levels
  output reg [WIDTH-1:0] sync_out // levels safe to use
);
  reg [WIDTH-1:0] meta_reg;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* gpalr_pin.v */
// single pin driver: gpio, alternate function, led sink and reset overrides
`timescale 1ns/10ps
`default_nettype none
module gpalr_pin (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire gpio_dout, // port output data
  input wire gpio_dir_in, // 1 = pin is an input
  input wire open_drain, // open-drain output selected
  input wire alt_en, // alternate function enabled
  input wire alt_dout, // selected peripheral output
  input wire alt_oe, // selected peripheral direction
  input wire led_mode, // led current sink active
  input wire osc_force, // crystal oscillator owns the pin
  input wire rst_mode, // pin acts as reset pin
  input wire rst_drive, // chip drives reset low
  input wire od_only, // gpio mode is output-only open drain
  output reg pin_out, // pad output level
  output reg pin_oe // pad output enable
);
  reg val;
  reg drv;
  reg odm;

  always @*
  begin
    val = gpio_dout;
    drv = ~gpio_dir_in;
    odm = open_drain;
    if (osc_force)
    begin
      val = 1'b0;
      drv = 1'b0;
      odm = 1'b0;
    end
    else if (rst_mode)
    begin
      val = 1'b0;
      drv = 1'b1;
      odm = 1'b1;
      if (!rst_drive)
        val = 1'b1;
    end
    else if (led_mode)
    begin
      val = 1'b0;
      drv = 1'b1;
      odm = 1'b0;
    end
    else if (alt_en)
    begin
      val = alt_dout;
      drv = alt_oe;
    end
    else if (od_only)
    begin
      drv = 1'b1;
      odm = 1'b1;
    end
  end

  // registered so pad outputs never glitch on config writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_out <= odm ? 1'b0 : val;
      pin_oe <= odm ? (drv & ~val) : drv;
    end
  end
endmodule
`default_nettype wire

/* gpalr_top.v */
// gpio ports a-d with axi4-lite registers, alternate functions, led sink, reset pin
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "gpalr_defines.vh"
module gpalr_top #(
  parameter [1:0] PKG = `GPALR_PKG_LARGE // package selection
) (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire [11:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [11:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [7:0] pa_in, // port a pad input
  output wire [7:0] pa_out, // port a pad output
  output wire [7:0] pa_oe, // port a pad output enable
  input wire [7:0] pb_in, // port b pad input
  output wire [7:0] pb_out, // port b pad output
  output wire [7:0] pb_oe, // port b pad output enable
  input wire [7:0] pc_in, // port c pad input
  output wire [7:0] pc_out, // port c pad output
  output wire [7:0] pc_oe, // port c pad output enable
  input wire [7:0] pd_in, // port d pad input
  output wire [7:0] pd_out, // port d pad output
  output wire [7:0] pd_oe, // port d pad output enable
  input wire [127:0] alt_dout, // peripheral outputs, port*32+set*8+bit
  input wire [127:0] alt_oe, // peripheral directions, same layout
  output wire [31:0] io_sync, // synchronised pin levels to peripherals
  output wire [31:0] pull_up_en, // pull-up enables, port*8+bit
  output wire [31:0] high_drive_en, // high drive enables
  output wire [31:0] smr_src_en, // stop-mode recovery source enables
  output wire [63:0] alt_set_sel, // active function set per pin
  input wire osc_xtal_en, // crystal oscillator enabled
  input wire [1:0] tmr_cmp_out, // timer 0/1 in complement-output mode
  input wire sys_rst_drive, // chip reset in progress, drive pin low
  output wire ext_rst_req_n, // reset request from reset pin, low active
  output wire [7:0] led_sink_on, // port c led driver on
  output wire [15:0] led_level // per pin level {high,low}
);
  localparam NCFG = 4 * `GPALR_NUM_FIELDS;

  reg [7:0] cfg_reg [0:NCFG-1];
  reg [7:0] led_sink_enable_reg;
  reg [7:0] led_level_high_reg;
  reg [7:0] led_level_low_reg;
  reg rst_gpio_reg;
  reg [11:0] aw_addr_reg;
  reg aw_full_reg;
  reg [7:0] w_data_reg;
  reg w_en_reg;
  reg w_full_reg;
  reg [31:0] rd_next;
  reg rd_ok;
  wire [31:0] pins_in;
  wire [31:0] pins_out;
  wire [31:0] pins_oe;
  wire [31:0] alt_en_v;
  wire [31:0] alt_set_select_one_v;
  wire [31:0] alt_set_select_two_v;
  wire [31:0] in_view;
  wire [31:0] dout_v;
  wire [31:0] dir_v;
  wire [31:0] od_v;
  wire [31:0] impl_v;
  wire [7:0] rst_pin_mask;
  integer i;

  // implemented pins of a port for the chosen package
  function [7:0] port_mask;
    input [1:0] port;
    begin
      port_mask = `GPALR_RST_ZERO;
      case (PKG)
        `GPALR_PKG_SMALL:
          if (port == 2'h0)
            port_mask = `GPALR_MASK_S_A;
        `GPALR_PKG_MID:
          case (port)
            2'h0: port_mask = `GPALR_MASK_M_A;
            2'h1: port_mask = `GPALR_MASK_M_B;
            2'h2: port_mask = `GPALR_MASK_M_C;
            default: port_mask = `GPALR_MASK_D;
          endcase
        default:
          case (port)
            2'h0: port_mask = `GPALR_MASK_M_A;
            2'h3: port_mask = `GPALR_MASK_D;
            default: port_mask = `GPALR_MASK_L_BC;
          endcase
      endcase
    end
  endfunction

  // index of a port field in the config array
  function [5:0] cfg_idx;
    input [1:0] port;
    input [3:0] field;
    begin
      cfg_idx = port * 6'd9 + {2'b00, field};
    end
  endfunction

  // per-field vector over all 32 pins, masked to implemented pins
  function [31:0] field_vec;
    input [3:0] field;
    begin
      field_vec = {cfg_reg[cfg_idx(2'h3, field)] & port_mask(2'h3),
                   cfg_reg[cfg_idx(2'h2, field)] & port_mask(2'h2),
                   cfg_reg[cfg_idx(2'h1, field)] & port_mask(2'h1),
                   cfg_reg[cfg_idx(2'h0, field)] & port_mask(2'h0)};
    end
  endfunction

  gpalr_sync #(
    .WIDTH(32)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({pd_in, pc_in, pb_in, pa_in}),
    .sync_out(pins_in)
  );

  // reset pin lives on port a bit two for the small package, else port d bit 0
  assign rst_pin_mask = (PKG == `GPALR_PKG_SMALL) ? 8'h04 : 8'h01;

  assign alt_en_v = field_vec(`GPALR_F_ALT);
  assign alt_set_select_one_v = field_vec(`GPALR_F_ALT_SET_SELECT_ONE);
  assign alt_set_select_two_v = field_vec(`GPALR_F_ALT_SET_SELECT_TWO);
  assign dout_v = field_vec(`GPALR_F_DOUT);
  assign dir_v = field_vec(`GPALR_F_DIR);
  assign od_v = field_vec(`GPALR_F_OD);
  assign impl_v = {port_mask(2'h3), port_mask(2'h2), port_mask(2'h1),
                   port_mask(2'h0)};

  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_pin
      localparam P = g / 8;
      localparam B = g % 8;
      wire [1:0] set_sel;
      wire is_rst;
      wire osc;
      wire tmr_pin;
      wire led;
      wire sel_oe;
      // ports a and d have a single alternate, set bits are ignored
      assign set_sel = (P == 0 || P == 3) ? 2'b00 :
                       {alt_set_select_two_v[g], alt_set_select_one_v[g]};
      assign alt_set_sel[2*g+1:2*g] = set_sel;
      assign is_rst = (P == ((PKG == `GPALR_PKG_SMALL) ? 0 : 3)) &&
                      rst_pin_mask[B] && !rst_gpio_reg;
      assign osc = (P == 0) && (B < 2) && osc_xtal_en;
      assign tmr_pin = (P == 0) && (B == 0 || B == 6);
      assign sel_oe = tmr_pin ? tmr_cmp_out[B/6] :
                      alt_oe[P*32+set_sel*8+B];
      // led sink only on port c, with the driver enable set
      assign led = (P == 2) && alt_en_v[g] && alt_set_select_one_v[g] &&
                   led_sink_enable_reg[B];
      gpalr_pin u_pin (
        .aclk(aclk),
        .aresetn(aresetn),
        .gpio_dout(dout_v[g]),
        // missing pins are held as inputs so they can never drive
        .gpio_dir_in(dir_v[g] | ~impl_v[g]),
        .open_drain(od_v[g]),
        .alt_en(alt_en_v[g]),
        .alt_dout(alt_dout[P*32+set_sel*8+B]),
        .alt_oe(sel_oe),
        .led_mode(led),
        .osc_force(osc),
        .rst_mode(is_rst),
        .rst_drive(sys_rst_drive),
        .od_only((P == 3) && (B == 0) && impl_v[g]),
        .pin_out(pins_out[g]),
        .pin_oe(pins_oe[g])
      );
    end
  endgenerate

  assign {pd_out, pc_out, pb_out, pa_out} = pins_out;
  assign {pd_oe, pc_oe, pb_oe, pa_oe} = pins_oe;

  // port d bit zero never reads as input in gpio mode; crystal pins read 0
  assign in_view = io_sync;
  assign io_sync = pins_in & {8'h00 | (port_mask(2'h3) & 8'hFE),
                   port_mask(2'h2), port_mask(2'h1),
                   port_mask(2'h0) & (osc_xtal_en ? 8'hFC : 8'hFF)};

  assign pull_up_en = field_vec(`GPALR_F_PULL) & 32'hFEFF_FFFF;
  assign high_drive_en = field_vec(`GPALR_F_HDRV) & 32'hFEFF_FFFF;
  assign smr_src_en = field_vec(`GPALR_F_SMR) & 32'hFEFF_FFFF;

  // reset request follows the pin only while it serves as reset
  assign ext_rst_req_n = rst_gpio_reg |
                         ((PKG == `GPALR_PKG_SMALL) ? pins_in[2] :
                          pins_in[24]);
  assign led_sink_on = led_sink_enable_reg & port_mask(2'h2);
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_led
      assign led_level[2*g+1:2*g] = {led_level_high_reg[g],
                                     led_level_low_reg[g]};
    end
  endgenerate

  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire [11:0] wa = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
  wire [7:0] wd = w_full_reg ? w_data_reg : s_axi_wdata[7:0];
  wire we_lane = w_full_reg ? w_en_reg : s_axi_wstrb[0];
  wire aw_have = aw_full_reg || (s_axi_awvalid && s_axi_awready);
  wire w_have = w_full_reg || (s_axi_wvalid && s_axi_wready);
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire wa_cfg = (wa[11:8] == 4'h0) && (wa[5:2] < 4'd9) && (wa[1:0] == 2'b00);
  wire wa_led = (wa[11:4] == 8'h10) && (wa[1:0] == 2'b00);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i = 0; i < NCFG; i = i + 1)
        cfg_reg[i] <= ((i % 9) == 1) ? `GPALR_RST_DIR : `GPALR_RST_ZERO;
      led_sink_enable_reg <= `GPALR_RST_ZERO;
      led_level_high_reg <= `GPALR_RST_ZERO;
      led_level_low_reg <= `GPALR_RST_ZERO;
      rst_gpio_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_full_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_en_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPALR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !do_write)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_write)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_en_reg <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa_cfg || wa_led) ? `GPALR_RESP_OKAY :
                       `GPALR_RESP_SLVERR;
        if (we_lane && wa_cfg)
          cfg_reg[cfg_idx(wa[7:6], wa[5:2])] <= wd &
                                                 port_mask(wa[7:6]);
        if (we_lane && wa_led)
          case (wa)
            `GPALR_OFF_LED_EN: led_sink_enable_reg <= wd;
            `GPALR_OFF_LED_HI: led_level_high_reg <= wd;
            `GPALR_OFF_LED_LO: led_level_low_reg <= wd;
            default: rst_gpio_reg <= wd[0];
          endcase
      end
    end
  end

  // read decode; unmapped addresses answer slverr with zero data
  wire [11:0] ra = s_axi_araddr;
  always @*
  begin
    rd_next = 32'h0000_0000;
    rd_ok = 1'b1;
    if (ra[1:0] != 2'b00 || ra[11:9] != 3'h0)
      rd_ok = 1'b0;
    else if (!ra[8])
    begin
      if (ra[5:2] == `GPALR_F_IN)
        rd_next[7:0] = in_view[ra[7:6]*8 +: 8] & port_mask(ra[7:6]) &
                       ((ra[7:6] == 2'h3 && rst_gpio_reg) ? 8'hFE : 8'hFF);
      else if (ra[5:2] < 4'd9)
        rd_next[7:0] = cfg_reg[cfg_idx(ra[7:6], ra[5:2])];
      else
        rd_ok = 1'b0;
    end
    else
      case (ra)
        `GPALR_OFF_LED_EN: rd_next[7:0] = led_sink_enable_reg;
        `GPALR_OFF_LED_HI: rd_next[7:0] = led_level_high_reg;
        `GPALR_OFF_LED_LO: rd_next[7:0] = led_level_low_reg;
        `GPALR_OFF_RST_CTL: rd_next[0] = rst_gpio_reg;
        default: rd_ok = 1'b0;
      endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GPALR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_next;
      s_axi_rresp <= rd_ok ? `GPALR_RESP_OKAY : `GPALR_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

/* gpalr_props.sv */
// concurrent checks on the gpio port block pins and register bus
`timescale 1ns/10ps
`default_nettype none
module gpalr_props #(
  parameter [1:0] PKG = 2'h2 // package selection
) (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire s_axi_awvalid, // write address valid
  input wire s_axi_awready, // write address ready
  input wire s_axi_wvalid, // write data valid
  input wire s_axi_wready, // write data ready
  input wire [1:0] s_axi_bresp, // write response
  input wire s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire s_axi_arvalid, // read address valid
  input wire s_axi_arready, // read address ready
  input wire [31:0] s_axi_rdata, // read data
  input wire s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [7:0] pa_oe, // port a output enable
  input wire [7:0] pb_oe, // port b output enable
  input wire [7:0] pc_oe, // port c output enable
  input wire [7:0] pd_oe, // port d output enable
  input wire [31:0] io_sync, // synchronised levels
  input wire [31:0] pull_up_en, // pull-up enables
  input wire [31:0] high_drive_en, // high drive enables
  input wire [31:0] smr_src_en, // recovery source enables
  input wire [63:0] alt_set_sel, // active function set
  input wire osc_xtal_en, // crystal enabled
  input wire ext_rst_req_n, // reset request, low active
  input wire [7:0] led_sink_on // led drivers on
);
  localparam [7:0] MA = (PKG == 2'h0) ? 8'h3F : 8'hFF;
  localparam [7:0] MB = (PKG == 2'h2) ? 8'hFF : (PKG == 2'h1) ? 8'h0F : 8'h00;
  localparam [7:0] MD = (PKG == 2'h0) ? 8'h00 : 8'h01;
  localparam [7:0] RA = (PKG == 2'h0) ? 8'h04 : 8'h00;
  reg rst_seen;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // reset pin may legally drive during reset, so it is masked out
  always @(posedge aclk) rst_seen <= !aresetn;
  AST_RST_OE: assert property (rst_seen |-> ((pa_oe & ~RA) | pb_oe | pc_oe | pd_oe[7:1]) == 8'h00)
    else $error("pad driven right after reset");
  AST_UNIMPL: assert property (((pa_oe & ~MA) | (pb_oe & ~MB) | (pc_oe & ~MB) | (pd_oe & ~MD)) == 8'h00)
    else $error("missing pin driven");
  AST_PD0_FEAT: assert property (!pull_up_en[24] && !high_drive_en[24] && !smr_src_en[24])
    else $error("pd0 has pull, drive or recovery");
  AST_PD0_NOIN: assert property (io_sync[24] == 1'b0)
    else $error("pd0 used as input");
  AST_XTAL: assert property (osc_xtal_en [*2] |-> pa_oe[1:0] == 2'b00)
    else $error("crystal pins still driven");
  AST_SET_AD: assert property (alt_set_sel[15:0] == 16'h0000 && alt_set_sel[63:48] == 16'h0000)
    else $error("set select on single-function port");
  AST_LED: assert property ((led_sink_on & ~MB) == 8'h00)
    else $error("led driver on missing pin");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property (osc_xtal_en && pa_oe[1:0] == 2'b00);
  cover property (led_sink_on != 8'h00);
  cover property (!ext_rst_req_n);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind gpalr_top gpalr_props #(.PKG(PKG)) chk_u (.*);
`default_nettype wire

/* gpalr_pads.sv */
// far-side pad model: resolves pin levels from block and external drivers
`timescale 1ns/10ps
`default_nettype none
module gpalr_pads (
  input wire aclk, // system clock
  input wire [31:0] pad_out, // block pad outputs
  input wire [31:0] pad_oe, // block output enables
  input wire [31:0] pull_en, // pull-up enables
  input wire [31:0] ext_en, // external driver on
  input wire [31:0] ext_val, // external driver level
  output logic [31:0] level // resolved pad levels
);
  logic [31:0] last_q = 32'h0;
  always @(posedge aclk) last_q <= level;
  // far side pulls a pin only when told; a floating pin flips each cycle
  always @* level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & (pull_en | ~last_q));
endmodule
`default_nettype wire

/* gpalr_top_tb.sv */
// self-checking bench for the gpio port block
`timescale 1ns/10ps
`default_nettype none
`include "gpalr_defines.vh"
module gpalr_top_tb;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [31:0] e;} gpalr_row_t;
  logic aclk = 0, aresetn = 0, osc_xtal_en = 0, sys_rst_drive = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, ext_en = 0, ext_val = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [127:0] alt_dout = 0, alt_oe = 0;
  logic [1:0] tmr_cmp_out = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, io_sync, pull_up_en, high_drive_en, smr_src_en, lvl;
  wire [7:0] pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe, pd_out, pd_oe;
  wire [7:0] pa_in = lvl[7:0], pb_in = lvl[15:8];
  wire [7:0] pc_in = lvl[23:16], pd_in = lvl[31:24];
  wire [63:0] alt_set_sel;
  wire ext_rst_req_n;
  wire [7:0] led_sink_on;
  wire [15:0] led_level;
  int num_errors = 0, num_checks = 0;
  logic [31:0] d;
  logic [1:0] r;
  gpalr_row_t rows [7] = '{'{12'h044, 8'hA5, 32'hA5},
    '{12'h0C4, 8'hFF, 32'h01}, '{12'h05C, 8'h3C, 32'h3C},
    '{12'h108, 8'hC3, 32'hC3}, '{12'h014, 8'h0F, 32'h0F},
    '{12'h058, 8'h81, 32'h81}, '{12'h0E0, 8'hFF, 32'h01}};
  always #2.5 aclk = ~aclk;
  gpalr_top #(.PKG(`GPALR_PKG_LARGE)) dut_u (.*);
  gpalr_pads pads_u (.aclk(aclk), .pad_out({pd_out, pc_out, pb_out, pa_out}),
    .pad_oe({pd_oe, pc_oe, pb_oe, pa_oe}), .pull_en(pull_up_en),
    .ext_en(ext_en), .ext_val(ext_val), .level(lvl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [1:0] rs;
    axw(a, v, rs);
    chk(32'(rs), 32'(`GPALR_RESP_OKAY));
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    axr(a, v, rs);
    chk(v, e);
  endtask
  // pads are registered and inputs pass two flops, so four edges cover both
  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask
  task end_of_test;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    end_of_test;
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int p = 0; p < 4; p++)
    begin
      rdc(12'(p * 64 + 4), 32'hFF);
      rdc(12'(p * 64 + 8), 32'h00);
    end
    chk(32'(pd_oe[0]), 32'h0);
    sys_rst_drive <= 1'b1;
    settle;
    chk(32'({pd_oe[0], pd_out[0]}), 32'h2);
    sys_rst_drive <= 1'b0;
    ext_en[24] <= 1'b1;
    settle;
    chk(32'(ext_rst_req_n), 32'h0);
    ext_val[24] <= 1'b1;
    settle;
    chk(32'(ext_rst_req_n), 32'h1);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    chk(32'(pull_up_en[15:8]), 32'h3C);
    chk(32'(high_drive_en[15:8]), 32'h81);
    chk(32'(smr_src_en[31:24]), 32'h00);
    $display("test table done");
    wr(12'h014, 8'h00);
    wr(12'h004, 8'h00);
    wr(12'h000, 8'h5A);
    settle;
    chk(32'({pa_oe, pa_out}), 32'hFF5A);
    rdc(12'h024, 32'h5A);
    wr(12'h014, 8'h0F);
    settle;
    chk(32'(pa_oe), 32'hF5);
    osc_xtal_en <= 1'b1;
    settle;
    chk(32'({pa_oe[1:0], io_sync[1:0]}), 32'h0);
    osc_xtal_en <= 1'b0;
    wr(12'h014, 8'h00);
    wr(12'h008, 8'h01);
    settle;
    chk(32'(pa_oe[0]), 32'h0);
    tmr_cmp_out <= 2'b01;
    alt_dout[0] <= 1'b1;
    settle;
    chk(32'({pa_oe[0], pa_out[0]}), 32'h3);
    wr(12'h008, 8'h00);
    $display("test gpio done");
    alt_oe[56] <= 1'b1;
    wr(12'h04C, 8'h01);
    wr(12'h050, 8'h01);
    wr(12'h048, 8'h01);
    settle;
    chk(32'({pb_oe[0], pb_out[0]}), 32'h2);
    chk(32'(alt_set_sel[17:16]), 32'h3);
    wr(12'h044, 8'hA4);
    wr(12'h050, 8'h00);
    settle;
    chk(32'(pb_oe[0]), 32'h0);
    wr(12'h048, 8'h00);
    settle;
    chk(32'(pb_oe[0]), 32'h1);
    $display("test alt done");
    wr(12'h08C, 8'h01);
    wr(12'h088, 8'h01);
    wr(12'h100, 8'h01);
    for (int lv = 0; lv < 4; lv++)
    begin
      wr(12'h104, 8'(lv >> 1));
      wr(12'h108, 8'(lv & 1));
      settle;
      chk(32'({led_sink_on, led_level[1:0]}), 32'(4 + lv));
    end
    chk(32'({pc_oe[0], pc_out[0]}), 32'h2);
    wr(12'h100, 8'h00);
    settle;
    chk(32'(led_sink_on), 32'h0);
    $display("test led done");
    wr(12'h10C, 8'h01);
    wr(12'h0C0, 8'h01);
    settle;
    chk(32'(pd_oe[0]), 32'h0);
    wr(12'h0C0, 8'h00);
    ext_val[24] <= 1'b0;
    settle;
    chk(32'({pd_oe[0], pd_out[0], ext_rst_req_n}), 32'h5);
    rdc(12'h0E4, 32'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    chk(32'(ext_rst_req_n), 32'h0);
    rdc(12'h10C, 32'h0);
    ext_val[24] <= 1'b1;
    $display("test rstpin done");
    axw(12'h200, 8'h55, r);
    chk(32'(r), 32'(`GPALR_RESP_SLVERR));
    axr(12'h202, d, r);
    chk({d[29:0], r}, 32'(`GPALR_RESP_SLVERR));
    $display("test bus done");
    end_of_test;
  end
endmodule
`default_nettype wire
